//--- core/tgt_port.sv
// Host-facing I2C target port with clock stretching and sub-address
// framing of host interface commands.
// Assumes open-drain pads outside; pin levels are sampled on lnk_clk_in.
`timescale 1ns/10ps
`default_nettype none
module tgt_port (
    input wire logic mclk_in,                 // System clock, 20 MHz
    input wire logic arst_n_in,               // Async reset, active low
    input wire logic lnk_clk_in,              // Link sampling clock
    input wire logic scl_in,                  // Clock pin level
    output logic scl_out,                     // Clock pin drive value
    output logic scl_oe_n_out,                // Clock pin drive enable, low
    input wire logic sda_in,                  // Data pin level
    output logic sda_out,                     // Data pin drive value
    output logic sda_oe_n_out,                // Data pin drive enable, low
    input wire logic boot_done_in,            // Boot finished
    input wire logic [tgt_port_pkg::IDX_W-1:0] strap_idx_in, // Strap index
    input wire logic [6:0] cfg_addr_in,       // Address from configuration
    input wire logic cfg_valid_in,            // Configuration loaded
    output logic [7:0] cmd_sub_out,           // Sub-address of command
    output logic [7:0] cmd_data_out,          // Received data byte
    output logic cmd_wr_out,                  // Data byte strobe
    output logic cmd_start_out,               // New sub-address strobe
    output logic rsp_req_out,                 // Read byte wanted
    input wire logic [7:0] rsp_data_in,       // Read byte
    input wire logic rsp_valid_in,            // Read byte ready
    input wire logic host_ready_in            // Sink ready for next byte
);
    import tgt_port_pkg::*;

    // ************************************************************
    // Link-domain pin sampling
    // ************************************************************
    logic [2:0] scl_l_r, sda_l_r;
    logic scl_lk_r, sda_lk_r;
    always_ff @(posedge lnk_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scl_l_r <= 3'h7;
            sda_l_r <= 3'h7;
            scl_lk_r <= 1'b1;
            sda_lk_r <= 1'b1;
        end else begin
            scl_l_r <= {scl_l_r[1:0], scl_in};
            sda_l_r <= {sda_l_r[1:0], sda_in};
            if (scl_l_r[1] == scl_l_r[2])
                scl_lk_r <= scl_l_r[2];
            if (sda_l_r[1] == sda_l_r[2])
                sda_lk_r <= sda_l_r[2];
        end
    end

    // ************************************************************
    // Crossing into the system domain
    // ************************************************************
    logic [1:0] scl_x_r, sda_x_r;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scl_x_r <= 2'h3;
            sda_x_r <= 2'h3;
        end else begin
            scl_x_r <= {scl_x_r[0], scl_lk_r};
            sda_x_r <= {sda_x_r[0], sda_lk_r};
        end
    end
    wire logic scl_s = scl_x_r[1];
    wire logic sda_s = sda_x_r[1];

    // ************************************************************
    // Protocol engine
    // ************************************************************
    typedef struct packed {
        bus_state_e st;
        logic scl_p;
        logic sda_p;
        logic [2:0] bitn;
        logic full;
        logic [7:0] sh;
        logic rd;
        logic ack_low;
        logic sda_low;
        logic scl_low;
        logic [6:0] my_addr;
        logic addr_ok;
        logic [7:0] sub;
        logic [7:0] data;
        logic wr_p;
        logic start_p;
        logic req;
        logic have_rsp;
        bus_state_e after;
    } eng_s;

    eng_s q_r, q_nxt;

    wire logic scl_rise = scl_s & ~q_r.scl_p;
    wire logic scl_fall = ~scl_s & q_r.scl_p;
    wire logic start_c = scl_s & q_r.scl_p & q_r.sda_p & ~sda_s;
    wire logic stop_c = scl_s & q_r.scl_p & ~q_r.sda_p & sda_s;

    always_comb begin
        q_nxt = q_r;
        q_nxt.scl_p = scl_s;
        q_nxt.sda_p = sda_s;
        q_nxt.wr_p = 1'b0;
        q_nxt.start_p = 1'b0;
        // Address latched once boot and configuration are done
        if (boot_done_in && cfg_valid_in && !q_r.addr_ok) begin
            q_nxt.my_addr = cfg_addr_in + 7'(strap_idx_in);
            q_nxt.addr_ok = 1'b1;
        end
        if (rsp_valid_in && q_r.req) begin
            q_nxt.sh = rsp_data_in;
            q_nxt.have_rsp = 1'b1;
            q_nxt.req = 1'b0;
        end
        if (start_c) begin
            q_nxt.st = ST_ADDR;
            q_nxt.bitn = BIT_FIRST;
            q_nxt.full = 1'b0;
            q_nxt.sda_low = 1'b0;
            q_nxt.scl_low = 1'b0;
        end else if (stop_c) begin
            q_nxt.st = ST_IDLE;
            q_nxt.sda_low = 1'b0;
            q_nxt.scl_low = 1'b0;
        end else begin
            case (q_r.st)
                ST_IDLE: q_nxt.sda_low = 1'b0;
                ST_ADDR, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        q_nxt.sh = {q_r.sh[6:0], sda_s};
                        q_nxt.bitn = q_r.bitn + 3'h1;
                        q_nxt.full = (q_r.bitn == BIT_LAST);
                    end
                    // The fall just after START is no byte end
                    if (scl_fall && q_r.full) begin
                        q_nxt.st = ST_ACK;
                        q_nxt.after = q_r.st;
                        q_nxt.full = 1'b0;
                        q_nxt.scl_low = 1'b1;
                    end
                end
                ST_ACK: begin
                    // Decide ack while clock is held low
                    if (q_r.scl_low) begin
                        q_nxt.ack_low = 1'b1;
                        if (q_r.after == ST_ADDR) begin
                            q_nxt.ack_low = q_r.addr_ok &&
                                q_r.sh[7:1] == q_r.my_addr;
                            q_nxt.rd = q_r.sh[0];
                        end else if (q_r.after == ST_SUB) begin
                            q_nxt.sub = q_r.sh;
                            q_nxt.start_p = 1'b1;
                        end else begin
                            q_nxt.data = q_r.sh;
                            q_nxt.wr_p = 1'b1;
                        end
                        q_nxt.sda_low = q_nxt.ack_low;
                        q_nxt.scl_low = q_nxt.ack_low;
                        q_nxt.st = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Release clock only when the sink is ready
                    if (host_ready_in) begin
                        q_nxt.scl_low = 1'b0;
                    end
                    if (!q_r.scl_low && scl_fall) begin
                        q_nxt.sda_low = 1'b0;
                        q_nxt.bitn = BIT_FIRST;
                        if (!q_r.ack_low) begin
                            q_nxt.st = ST_IDLE;
                        end else if (q_r.after == ST_ADDR && q_r.rd) begin
                            q_nxt.st = ST_RD;
                            q_nxt.req = 1'b1;
                            q_nxt.have_rsp = 1'b0;
                            q_nxt.scl_low = 1'b1;
                        end else if (q_r.after == ST_ADDR) begin
                            q_nxt.st = ST_SUB;
                        end else begin
                            q_nxt.st = ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    // Stretch until the byte and its first bit are out
                    q_nxt.scl_low = 1'b1;
                    if (q_r.have_rsp) begin
                        if (q_r.sda_low == ~q_r.sh[7])
                            q_nxt.scl_low = 1'b0;
                        q_nxt.sda_low = ~q_r.sh[7];
                        if (scl_fall) begin
                            q_nxt.bitn = q_r.bitn + 3'h1;
                            if (q_r.bitn == BIT_LAST) begin
                                q_nxt.sda_low = 1'b0;
                                q_nxt.st = ST_RACK;
                            end else begin
                                q_nxt.sh = {q_r.sh[6:0], 1'b0};
                                q_nxt.sda_low = ~q_r.sh[6];
                            end
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        q_nxt.ack_low = ~sda_s;
                    end
                    if (scl_fall) begin
                        q_nxt.bitn = BIT_FIRST;
                        if (q_r.ack_low) begin
                            q_nxt.st = ST_RD;
                            q_nxt.req = 1'b1;
                            q_nxt.have_rsp = 1'b0;
                            q_nxt.scl_low = 1'b1;
                        end else begin
                            q_nxt.st = ST_IDLE;
                        end
                    end
                end
                default: q_nxt.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_r <= '0;
            q_r.scl_p <= 1'b1;
            q_r.sda_p <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign scl_out = 1'b0;
    assign scl_oe_n_out = ~q_r.scl_low;
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~q_r.sda_low;
    assign cmd_sub_out = q_r.sub;
    assign cmd_data_out = q_r.data;
    assign cmd_wr_out = q_r.wr_p;
    assign cmd_start_out = q_r.start_p;
    assign rsp_req_out = q_r.req;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    scl_sink_only_a: assert property (!scl_oe_n_out |->
        scl_out == 1'b0 && q_r.st inside {ST_ACK, ST_HOLD, ST_RD})
        else $error("clock pin driven high or outside a stretch");
    no_ack_preboot_a: assert property (
        !q_r.addr_ok && q_r.st == ST_HOLD && q_r.after == ST_ADDR
        |-> !q_r.ack_low)
        else $error("address acked before boot");
    stretch_hold_a: assert property (
        q_r.st == ST_HOLD && q_r.scl_low && !host_ready_in
        |=> !scl_oe_n_out)
        else $error("clock released while not ready");
    sequence stretch_ready_s;
        q_r.st == ST_HOLD && q_r.scl_low && host_ready_in;
    endsequence
    release_ready_a: assert property (stretch_ready_s |=> scl_oe_n_out)
        else $error("clock not released when ready");
    rd_stretch_a: assert property (
        q_r.st == ST_RD && !q_r.have_rsp && !rsp_valid_in
        |=> !scl_oe_n_out)
        else $error("read byte not stretched");
    ack_data_a: assert property (
        q_r.st == ST_HOLD && q_r.ack_low |-> !sda_oe_n_out)
        else $error("ack not driven");
    addr_src_a: assert property (
        $rose(q_r.addr_ok) |-> q_r.my_addr ==
        $past(cfg_addr_in) + 7'($past(strap_idx_in)))
        else $error("address not from configuration");
    wr_strobe_a: assert property (
        cmd_wr_out |-> q_r.st == ST_HOLD ##1 !cmd_wr_out)
        else $error("write strobe malformed");
endmodule
`default_nettype wire

//--- core/tgt_port_pkg.sv
// Constants and types for the host-facing I2C target port.
// Assumes a 20 MHz system clock and a separate link clock for pin sampling.
package tgt_port_pkg;
    localparam int unsigned SYS_CLK_HZ = 20000000;
    localparam int unsigned HOLD_NS = 4000;
    localparam int unsigned HOLD_CYC =
        (HOLD_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [6:0] DEF_ADDR_BASE = 7'h20;
    localparam logic [3:0] IDX_W = 4'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SUB  = 3'b011,
        ST_WR   = 3'b010,
        ST_RD   = 3'b110,
        ST_ACK  = 3'b111,
        ST_RACK = 3'b101,
        ST_HOLD = 3'b100
    } bus_state_e;
endpackage

//--- verif/i2c_ctrl_model.sv
// Behavioural bus controller that faces the target port.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model #(
    parameter int QTR_NS = 2500,
    parameter int HOLD_NS = 4000
) (
    input wire logic scl_in,       // Resolved clock line
    input wire logic sda_in,       // Resolved data line
    output logic scl_oe_n_out,     // Low pulls the clock line
    output logic sda_oe_n_out      // Low pulls the data line
);
    int wait_ns;
    initial begin
        scl_oe_n_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end
    // Releases the clock, waits out a stretch of up to 2 ms, keeps it high for HOLD_NS, then pulls it low
    task automatic pulse(input logic b, output logic s);
        sda_oe_n_out = b;
        #(QTR_NS);
        scl_oe_n_out = 1'b1;
        wait_ns = 0;
        while (scl_in !== 1'b1 && wait_ns < 2000000) begin
            #10;
            wait_ns += 10;
        end
        #(HOLD_NS);
        s = sda_in;
        scl_oe_n_out = 1'b0;
        #(QTR_NS);
    endtask
    task automatic start();
        sda_oe_n_out = 1'b1;
        scl_oe_n_out = 1'b1;
        #(HOLD_NS);
        sda_oe_n_out = 1'b0;
        #(HOLD_NS);
        scl_oe_n_out = 1'b0;
        #(QTR_NS);
    endtask
    task automatic stop();
        sda_oe_n_out = 1'b0;
        #(QTR_NS);
        scl_oe_n_out = 1'b1;
        #(HOLD_NS);
        sda_oe_n_out = 1'b1;
        #(HOLD_NS);
    endtask
    task automatic xfer(input logic [7:0] wb, input logic ack_n,
                        output logic [7:0] rb, output logic ack_seen);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(wb[i], s);
            rb[i] = s;
        end
        pulse(ack_n, ack_seen);
    endtask
endmodule
`default_nettype wire

//--- verif/tgt_port_test.sv
// Self-checking bench for the target port.
// Assumes pull-ups on both lines and the controller model beside it.
`timescale 1ns/10ps
`default_nettype none
module tgt_port_test;
    import tgt_port_pkg::*;
    logic mclk_in, lnk_clk_in, arst_n_in, boot_done_in, cfg_valid_in;
    logic rsp_valid_in, host_ready_in, ack;
    logic [IDX_W-1:0] strap_idx_in;
    logic [6:0] cfg_addr_in, addr;
    logic [7:0] rsp_data_in, cmd_sub_out, cmd_data_out, rb;
    logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
    logic cmd_wr_out, cmd_start_out, rsp_req_out, m_scl_oe_n, m_sda_oe_n;
    wire logic scl = scl_oe_n_out & m_scl_oe_n;
    wire logic sda = sda_oe_n_out & m_sda_oe_n;
    int num_errors, n_tests;
    logic [7:0] got_q[$], rd_q[$], exp_q[$];

    tgt_port DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .lnk_clk_in(lnk_clk_in), .scl_in(scl), .scl_out(scl_out),
        .scl_oe_n_out(scl_oe_n_out), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n_out(sda_oe_n_out), .boot_done_in(boot_done_in),
        .strap_idx_in(strap_idx_in), .cfg_addr_in(cfg_addr_in),
        .cfg_valid_in(cfg_valid_in), .cmd_sub_out(cmd_sub_out),
        .cmd_data_out(cmd_data_out), .cmd_wr_out(cmd_wr_out),
        .cmd_start_out(cmd_start_out), .rsp_req_out(rsp_req_out),
        .rsp_data_in(rsp_data_in), .rsp_valid_in(rsp_valid_in),
        .host_ready_in(host_ready_in));
    i2c_ctrl_model m (.scl_in(scl), .sda_in(sda),
        .scl_oe_n_out(m_scl_oe_n), .sda_oe_n_out(m_sda_oe_n));

    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    initial begin
        lnk_clk_in = 1'b0;
        #3.3;
        forever #7.5 lnk_clk_in = ~lnk_clk_in;
    end
    always @(negedge mclk_in) begin
        if (cmd_start_out === 1'b1) got_q.push_back(cmd_sub_out);
        if (cmd_wr_out === 1'b1) got_q.push_back(cmd_data_out);
    end
    // Read sink hands one prepared byte per request
    always @(negedge mclk_in) begin
        if (rsp_req_out === 1'b1 && !rsp_valid_in && rd_q.size() > 0) begin
            rsp_data_in <= rd_q.pop_front();
            rsp_valid_in <= 1'b1;
        end else if (rsp_req_out !== 1'b1) rsp_valid_in <= 1'b0;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Target address: configured base plus strap index
    function automatic logic [6:0] tgt_addr(input logic [6:0] base,
                                            input logic [IDX_W-1:0] idx);
        return base + 7'(idx);
    endfunction
    task automatic wr(input logic [6:0] a, input int n, input logic exp_ack);
        logic [7:0] d;
        m.start();
        m.xfer({a, 1'b0}, 1'b1, rb, ack);
        check({7'h00, ack}, {7'h00, !exp_ack});
        for (int i = 0; i < n && exp_ack; i++) begin
            d = (i == 1) ? 8'hFF : 8'($urandom);
            exp_q.push_back(d);
            m.xfer(d, 1'b1, rb, ack);
            check({7'h00, ack}, 8'h00);
        end
        m.stop();
        check(8'(got_q.size()), 8'(exp_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0)
            check(got_q.pop_front(), exp_q.pop_front());
        got_q = {};
        exp_q = {};
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        logic [7:0] e[$];
        for (int i = 0; i < n; i++) rd_q.push_back(8'($urandom));
        e = rd_q;
        m.start();
        m.xfer({a, 1'b1}, 1'b1, rb, ack);
        check({7'h00, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, i == n - 1, rb, ack);
            check(rb, e[i]);
        end
        m.stop();
        rd_q = {};
    endtask

    initial begin
        #4000000;
        num_errors++;
        summarize();
    end
    initial begin
        num_errors = 0;
        n_tests = 0;
        arst_n_in = 1'b0;
        boot_done_in = 1'b0;
        cfg_valid_in = 1'b1;
        host_ready_in = 1'b1;
        rsp_valid_in = 1'b0;
        rsp_data_in = 8'h00;
        void'($urandom(32'h4dfd));
        strap_idx_in = IDX_W'($urandom);
        cfg_addr_in = 7'($urandom);
        addr = tgt_addr(cfg_addr_in, strap_idx_in);
        repeat (4) @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        wr(addr, 1, 1'b0);
        @(negedge mclk_in);
        boot_done_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        wr(addr ^ 7'h01, 1, 1'b0);
        @(negedge mclk_in);
        host_ready_in = 1'b0;
        fork
            wr(addr, 2, 1'b1);
            begin
                wait (scl_oe_n_out === 1'b0);
                repeat (100) @(negedge mclk_in);
                check({5'h00, sda_out, scl, scl_out}, 8'h00);
                host_ready_in = 1'b1;
            end
        join
        for (int k = 0; k < 3; k++) begin
            wr(addr, k + 2, 1'b1);
            rd(addr, k + 1);
        end
        summarize();
    end
endmodule
`default_nettype wire
